// File: rtl/sfc_afc_loop.sv
// Purpose: AFC measure/settle loop producing a signed LO correction
// Assumes: rx_bit_tick pulses once per received bit period
// Notes: Correction unit is 156.25 Hz times (band bit + 1)
`timescale 1ns/1ns
`default_nettype none
module sfc_afc_loop
    import sfc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire sfc_afc_cfg_s cfg,
    input wire logic rx_active,
    input wire logic rx_bit_tick,
    input wire logic signed [9:0] freq_err,
    input wire logic preamble_det,
    input wire logic pkt_end,
    output logic signed [9:0] corr_r
);
    typedef struct packed {
        logic [4:0] cnt;
        logic signed [11:0] acc;
        logic signed [9:0] corr;
        logic frozen;
    } sfc_afc_s;
    sfc_afc_s s_r, s_nxt;
    logic signed [12:0] step;
    logic signed [12:0] sum;
    logic signed [12:0] lim;
    logic [4:0] last_bit;

    // Two measure bits, then settle; shwait 1 gives 4 bits per cycle
    always_comb begin
        s_nxt = s_r;
        last_bit = {1'b0, cfg.shwait, 1'b0} + 5'h01;
        step = 13'(s_r.acc + 12'(freq_err)) >>> (1 + cfg.gear);
        sum = 13'(s_r.corr) + step;
        lim = 13'({cfg.limit, 2'b00});
        if (lim > 13'sh01ff) lim = 13'sh01ff;
        if (!rx_active || !cfg.en || cfg.shwait == 3'h0 || (pkt_end && cfg.multi_pkt)) begin
            s_nxt = '0;
        end else if (preamble_det || s_r.frozen) begin
            s_nxt.frozen = 1'b1;
        end else if (rx_bit_tick) begin
            s_nxt.cnt = (s_r.cnt == last_bit) ? 5'h00 : 5'(s_r.cnt + 5'h01);
            if (s_r.cnt == 5'h00) s_nxt.acc = 12'(freq_err);
            if (s_r.cnt == 5'h01) begin
                if (sum > lim) s_nxt.corr = 10'(lim);
                else if (sum < -lim) s_nxt.corr = 10'(-lim);
                else s_nxt.corr = 10'(sum);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) s_r <= '0;
        else s_r <= s_nxt;
    end
    assign corr_r = s_r.corr;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_afc_freeze: assert property (s_r.frozen && rx_active && cfg.en && cfg.shwait != 3'h0
        && !pkt_end |=> $stable(corr_r))
        else $error("AFC moved after preamble");
    // Signed compare, so a negative correction is bounded from below too
    a_afc_clamp: assert property (13'(corr_r) <= $signed({3'b000, cfg.limit, 2'b00})
        && -13'(corr_r) <= $signed({3'b000, cfg.limit, 2'b00}) || $changed(cfg.limit))
        else $error("AFC beyond pull-in limit");
    a_afc_off: assert property (cfg.shwait == 3'h0 |=> corr_r == 10'sh000)
        else $error("AFC output with cycle code zero");
endmodule : sfc_afc_loop
`default_nettype wire

// File: rtl/sfc_freq_ctrl.sv
// Purpose: Frequency-control top: hop retune, deviation, offset/AFC, TX rate
// Assumes: Register port writes are single-cycle strobes; status inputs synchronous
// Notes: Read data returns one cycle after the address is presented
`timescale 1ns/1ns
`default_nettype none
module sfc_freq_ctrl
    import sfc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic reg_we,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_r,
    input wire logic tx_on,
    input wire logic rx_on,
    input wire logic tx_fifo_mode,
    input wire logic tx_pkt_busy,
    input wire logic afc_en,
    input wire logic [2:0] afc_gear,
    input wire logic [2:0] afc_shwait,
    input wire logic rx_multi_pkt,
    input wire logic rx_bit_tick,
    input wire logic signed [9:0] rx_freq_err,
    input wire logic preamble_det,
    input wire logic rx_pkt_end,
    output logic [3:0] radio_state_r,
    output sfc_hop_s hop_applied_r,
    output logic retune_r,
    output logic high_band_r,
    output logic [18:0] dev_hz_r,
    output logic signed [31:0] lo_shift_mhz_r,
    output logic tx_bit_tick_r
);
    typedef struct packed {
        sfc_state_e st;
        sfc_state_e back;
        logic [7:0] tune_cnt;
        logic pend;
        logic retune;
        logic [7:0] rate_hi;
        logic [7:0] rate_lo;
        logic scale;
        logic [7:0] mod2;
        logic [7:0] dev;
        logic [9:0] ofs;
        logic [7:0] limit;
        logic [7:0] band;
        sfc_hop_s hop_wr;
        sfc_hop_s hop_app;
        logic [7:0] rdata;
        logic [18:0] dev_hz;
        logic signed [31:0] lo_shift;
    } sfc_main_s;

    sfc_main_s s_r, s_nxt;
    sfc_afc_cfg_s afc_cfg;
    logic signed [9:0] afc_corr;
    logic hop_we;
    logic defer;
    logic use_afc;
    logic signed [9:0] corr_sel;
    logic signed [31:0] corr_band;

    // Enter retune: apply latest hop values, remember where to return
    function automatic sfc_main_s start_tune(sfc_main_s x, sfc_state_e back);
        sfc_main_s y;
        y = x;
        y.hop_app = x.hop_wr;
        y.pend = 1'b0;
        y.back = back;
        y.st = ST_TUNE;
        y.tune_cnt = 8'(TUNE_CYC - 1);
        y.retune = 1'b1;
        return y;
    endfunction : start_tune

    // Register read decode; the 2Bh readback is live loop state
    function automatic logic [7:0] reg_read(sfc_main_s x, logic [6:0] a, logic signed [9:0] c);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            ADDR_AFC_LIMIT: d = x.limit;
            ADDR_AFC_CORR: d = c[7:0];
            ADDR_TX_RATE_HIGH: d = x.rate_hi;
            ADDR_TX_RATE_LOW: d = x.rate_lo;
            ADDR_RATE_SCALE: d = 8'(x.scale) << SCALE_BIT;
            ADDR_MOD_CTRL2: d = x.mod2;
            ADDR_DEV_LOW: d = x.dev;
            ADDR_OFS_LOW: d = x.ofs[7:0];
            ADDR_OFS_HIGH: d = {6'h00, x.ofs[9:8]};
            ADDR_BAND: d = x.band;
            ADDR_HOP_CH: d = x.hop_wr.ch;
            ADDR_HOP_STEP: d = x.hop_wr.step;
            default: d = 8'h00;
        endcase
        return d;
    endfunction : reg_read

    // Hop write strobes and TX packet deferral condition
    assign hop_we = reg_we && (reg_addr == ADDR_HOP_CH || reg_addr == ADDR_HOP_STEP);
    assign defer = tx_fifo_mode && tx_pkt_busy;

    // Shared correction: AFC only while receiving with AFC on, else manual
    assign use_afc = afc_en && s_r.st == ST_RX;
    assign corr_sel = use_afc ? afc_corr : $signed(s_r.ofs);
    assign corr_band = 32'(corr_sel) <<< s_r.band[BAND_HBSEL_BIT];

    assign afc_cfg = '{en: afc_en, gear: afc_gear, shwait: afc_shwait,
                       limit: s_r.limit, multi_pkt: rx_multi_pkt};

    // Next-state logic for registers and the retune sequencer
    always_comb begin
        s_nxt = s_r;
        s_nxt.retune = 1'b0;
        if (reg_we) begin
            case (reg_addr)
                ADDR_AFC_LIMIT: s_nxt.limit = reg_wdata;
                ADDR_TX_RATE_HIGH: s_nxt.rate_hi = reg_wdata;
                ADDR_TX_RATE_LOW: s_nxt.rate_lo = reg_wdata;
                ADDR_RATE_SCALE: s_nxt.scale = reg_wdata[SCALE_BIT];
                ADDR_MOD_CTRL2: s_nxt.mod2 = reg_wdata;
                ADDR_DEV_LOW: s_nxt.dev = reg_wdata;
                ADDR_OFS_LOW: s_nxt.ofs[7:0] = reg_wdata;
                ADDR_OFS_HIGH: s_nxt.ofs[9:8] = reg_wdata[1:0];
                ADDR_BAND: s_nxt.band = reg_wdata;
                ADDR_HOP_CH: s_nxt.hop_wr.ch = reg_wdata;
                ADDR_HOP_STEP: s_nxt.hop_wr.step = reg_wdata;
                default: ;
            endcase
        end
        unique case (s_r.st)
            ST_IDLE: begin
                // No RF activity: hop values apply at once
                s_nxt.hop_app = s_nxt.hop_wr;
                s_nxt.pend = 1'b0;
                if (tx_on) s_nxt.st = ST_TX;
                else if (rx_on) s_nxt.st = ST_RX;
            end
            ST_TX: begin
                if ((hop_we || s_r.pend) && defer) begin
                    s_nxt.pend = 1'b1;
                end else if (hop_we || s_r.pend) begin
                    s_nxt = start_tune(s_nxt, ST_TX);
                end else if (!tx_on) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_RX: begin
                if (hop_we) s_nxt = start_tune(s_nxt, ST_RX);
                else if (!rx_on) s_nxt.st = ST_IDLE;
            end
            ST_TUNE: begin
                // A further hop write restarts the settle with new values
                if (hop_we) s_nxt = start_tune(s_nxt, s_r.back);
                else if (s_r.tune_cnt == 8'h00) s_nxt.st = s_r.back;
                else s_nxt.tune_cnt = 8'(s_r.tune_cnt - 8'h01);
            end
        endcase
        // Derived outputs, registered so every output is a flop
        s_nxt.rdata = reg_read(s_r, reg_addr, afc_corr);
        s_nxt.dev_hz = {10'h000, s_r.mod2[MOD2_DEV_MSB_BIT], s_r.dev} * DEV_STEP_HZ;
        s_nxt.lo_shift = corr_band * $signed(OFS_STEP_MILLIHZ);
    end

    // State register; constants only under reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.back <= ST_IDLE;
            s_r.rate_hi <= RST_TX_RATE_HIGH;
            s_r.rate_lo <= RST_TX_RATE_LOW;
            s_r.mod2 <= RST_MOD_CTRL2;
            s_r.dev <= RST_DEV_LOW;
            s_r.ofs <= RST_OFS;
            s_r.limit <= RST_AFC_LIMIT;
            s_r.band <= RST_BAND;
            s_r.hop_wr <= {RST_HOP, RST_HOP};
            s_r.hop_app <= {RST_HOP, RST_HOP};
        end else begin
            s_r <= s_nxt;
        end
    end

    // AFC loop runs only in RX and feeds the shared correction
    sfc_afc_loop i_sfc_afc_loop (
        .clk(clk),
        .nrst(nrst),
        .cfg(afc_cfg),
        .rx_active(s_r.st == ST_RX),
        .rx_bit_tick(rx_bit_tick),
        .freq_err(rx_freq_err),
        .preamble_det(preamble_det),
        .pkt_end(rx_pkt_end),
        .corr_r(afc_corr)
    );

    // TX rate generator sees TX state only, so RX never depends on it
    sfc_rate_gen i_sfc_rate_gen (
        .clk(clk),
        .nrst(nrst),
        .tx_active(s_r.st == ST_TX),
        .rate_word({s_r.rate_hi, s_r.rate_lo}),
        .scale(s_r.scale),
        .bit_tick_r(tx_bit_tick_r)
    );

    // Outputs straight from the state flops
    assign reg_rdata_r = s_r.rdata;
    assign radio_state_r = s_r.st;
    assign hop_applied_r = s_r.hop_app;
    assign retune_r = s_r.retune;
    assign high_band_r = s_r.band[BAND_HBSEL_BIT];
    assign dev_hz_r = s_r.dev_hz;
    assign lo_shift_mhz_r = s_r.lo_shift;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_retune_enter: assert property (s_r.st == ST_RX && hop_we |=> s_r.st == ST_TUNE && retune_r)
        else $error("RX hop write did not retune");
    a_retune_return: assert property (s_r.st == ST_TUNE && s_r.tune_cnt == 8'h00 && !hop_we
        |=> s_r.st == $past(s_r.back))
        else $error("Retune did not return to prior state");
    a_tx_defer: assert property (s_r.st == ST_TX && hop_we && defer
        |=> s_r.st == ST_TX && s_r.pend && $stable(hop_applied_r))
        else $error("Hop applied during TX packet");
    a_latest_hop: assert property (s_r.st == ST_TX && s_r.pend && !defer && !hop_we
        |=> s_r.st == ST_TUNE && hop_applied_r == $past(s_r.hop_wr))
        else $error("Deferred hop not applied with latest values");
    // No attempt from the release edge: the flop still holds its reset zero there
    a_dev_scale: assert property (nrst
        |=> dev_hz_r == 19'({$past(s_r.mod2[MOD2_DEV_MSB_BIT]), $past(s_r.dev)}) * DEV_STEP_HZ)
        else $error("Deviation not code times step");
    // Output lags the code by one edge, so compare with the earlier code
    a_manual_ofs: assert property (!afc_en && $stable(s_r.ofs) && $stable(s_r.band)
        |=> lo_shift_mhz_r == (32'($signed($past(s_r.ofs))) <<< $past(s_r.band[BAND_HBSEL_BIT]))
            * $signed(OFS_STEP_MILLIHZ))
        else $error("Manual offset not applied");
    a_ofs_range: assert property (!afc_en
        |=> lo_shift_mhz_r <= 32'sd160000000 && lo_shift_mhz_r >= -32'sd160000000)
        else $error("Offset outside range");
    a_afc_only_rx: assert property (s_r.st != ST_RX && $stable(s_r.ofs) && $stable(s_r.band)
        |=> lo_shift_mhz_r == (32'($signed($past(s_r.ofs))) <<< $past(s_r.band[BAND_HBSEL_BIT]))
            * $signed(OFS_STEP_MILLIHZ))
        else $error("AFC correction used outside RX");
endmodule : sfc_freq_ctrl
`default_nettype wire

// File: rtl/sfc_pkg.sv
// Purpose: Shared constants and types for the synthesizer frequency-control block
// Assumes: 20 MHz clock, 7-bit radio register addresses, 8-bit register data
// Notes: Register addresses, reset values, field positions, scale steps and timing
package sfc_pkg;
    // Register addresses
    localparam logic [6:0] ADDR_AFC_LIMIT = 7'h2a;
    localparam logic [6:0] ADDR_AFC_CORR = 7'h2b;
    localparam logic [6:0] ADDR_TX_RATE_HIGH = 7'h6e;
    localparam logic [6:0] ADDR_TX_RATE_LOW = 7'h6f;
    localparam logic [6:0] ADDR_RATE_SCALE = 7'h70;
    localparam logic [6:0] ADDR_MOD_CTRL2 = 7'h71;
    localparam logic [6:0] ADDR_DEV_LOW = 7'h72;
    localparam logic [6:0] ADDR_OFS_LOW = 7'h73;
    localparam logic [6:0] ADDR_OFS_HIGH = 7'h74;
    localparam logic [6:0] ADDR_BAND = 7'h75;
    localparam logic [6:0] ADDR_HOP_CH = 7'h79;
    localparam logic [6:0] ADDR_HOP_STEP = 7'h7a;
    // Reset values
    localparam logic [7:0] RST_TX_RATE_HIGH = 8'h0a;
    localparam logic [7:0] RST_TX_RATE_LOW = 8'h3d;
    localparam logic [7:0] RST_MOD_CTRL2 = 8'h00;
    localparam logic [7:0] RST_DEV_LOW = 8'h20;
    localparam logic [9:0] RST_OFS = 10'h000;
    localparam logic [7:0] RST_BAND = 8'h35;
    localparam logic [7:0] RST_AFC_LIMIT = 8'h00;
    localparam logic [7:0] RST_HOP = 8'h00;
    // Field positions
    localparam int MOD2_DEV_MSB_BIT = 2;
    localparam int BAND_HBSEL_BIT = 5;
    localparam int SCALE_BIT = 0;
    // Scale steps
    localparam logic [18:0] DEV_STEP_HZ = 19'h0_0271;
    localparam logic [31:0] OFS_STEP_MILLIHZ = 32'h0002_625a;
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int REF_HZ = 1_000_000;
    localparam int REF_DIV = CLK_HZ / REF_HZ;
    localparam int TUNE_NS = 1000;
    localparam int TUNE_CYC = (TUNE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Radio operating states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_TX = 4'b0010,
        ST_RX = 4'b0100,
        ST_TUNE = 4'b1000
    } sfc_state_e;
    // Hop channel and step pair
    typedef struct packed {
        logic [7:0] ch;
        logic [7:0] step;
    } sfc_hop_s;
    // AFC loop settings
    typedef struct packed {
        logic en;
        logic [2:0] gear;
        logic [2:0] shwait;
        logic [7:0] limit;
        logic multi_pkt;
    } sfc_afc_cfg_s;
endpackage : sfc_pkg

// File: rtl/sfc_rate_gen.sv
// Purpose: TX bit-rate tick generator from a 1 MHz reference phase accumulator
// Assumes: Clock is an exact multiple of the 1 MHz reference
// Notes: Runs only while transmitting
`timescale 1ns/1ns
`default_nettype none
module sfc_rate_gen
    import sfc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic tx_active,
    input wire logic [15:0] rate_word,
    input wire logic scale,
    output logic bit_tick_r
);
    typedef struct packed {
        logic [4:0] pre;
        logic [20:0] acc;
        logic tick;
    } sfc_rate_s;
    sfc_rate_s s_r, s_nxt;
    logic [21:0] sum;

    // Accumulate word per reference tick; carry out is one bit time
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        sum = {1'b0, s_r.acc} + {6'h00, rate_word};
        if (!tx_active) begin
            s_nxt = '0;
        end else if (s_r.pre == 5'(REF_DIV - 1)) begin
            s_nxt.pre = 5'h00;
            s_nxt.tick = scale ? sum[21] : sum[16];
            s_nxt.acc = scale ? sum[20:0] : {5'h00, sum[15:0]};
        end else begin
            s_nxt.pre = 5'(s_r.pre + 5'h01);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) s_r <= '0;
        else s_r <= s_nxt;
    end
    assign bit_tick_r = s_r.tick;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_rate_idle: assert property (!tx_active |=> !bit_tick_r)
        else $error("Rate tick outside TX");
endmodule : sfc_rate_gen
`default_nettype wire

// File: tb/sfc_host_model.sv
// Purpose: Host model that drives the radio register port
// Assumes: Requests are launched just after a rising edge
// Notes: The bench calls these tasks; the strobe is a single-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module sfc_host_model
    import sfc_pkg::*;
(
    input wire logic clk,
    output logic reg_we,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r
);
    // Preamble bits the host would program with AFC on; no port for it here
    localparam int PREAMBLE_AFC_BITS = 40;

    // Idle port at time zero
    initial begin
        reg_we = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end

    // Strobe goes up on one edge and is taken on the next
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
        reg_wdata <= ~d; // Data is not held past the strobe
    endtask : wr

    // Read data is registered one edge after the address
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 d = reg_rdata_r;
    endtask : rd

    // Rate word and scale; fast rates also need the modem tuning write
    task automatic set_rate(input logic [15:0] w, input logic s);
        wr(ADDR_TX_RATE_HIGH, w[15:8]);
        wr(ADDR_TX_RATE_LOW, w[7:0]);
        wr(ADDR_RATE_SCALE, {7'h00, s});
        if (!s && w > 16'h1999) begin
            wr(7'h58, 8'hc0);
        end
    endtask : set_rate
endmodule : sfc_host_model
`default_nettype wire

// File: tb/tb_sfc_freq_ctrl.sv
// Purpose: Self-checking bench for the frequency-control block
// Assumes: Host model owns the register port; status pins driven here
// Notes: Random values come from a fixed seed; bench functions give expectations
`timescale 1ns/1ns
`default_nettype none
module tb_sfc_freq_ctrl
    import sfc_pkg::*;
;
    localparam int DEV_HZ = 625;
    localparam int OFS_MHZ = 156250;
    logic clk = 1'b0, nrst = 1'b0, reg_we, retune_r, high_band_r, tx_bit_tick_r;
    logic tx_on = 1'b0, rx_on = 1'b0, tx_fifo_mode = 1'b0, tx_pkt_busy = 1'b0;
    logic afc_en = 1'b0, rx_multi_pkt = 1'b0, rx_bit_tick = 1'b0;
    logic preamble_det = 1'b0, rx_pkt_end = 1'b0;
    logic [2:0] afc_gear = 3'h0, afc_shwait = 3'h1;
    logic signed [9:0] rx_freq_err = 10'sh000;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_r, r, v;
    logic [3:0] radio_state_r;
    logic [18:0] dev_hz_r;
    logic signed [31:0] lo_shift_mhz_r;
    sfc_hop_s hop_applied_r, he;
    logic [9:0] oc;
    logic [8:0] dc;
    logic [6:0] ra [6] = '{ADDR_TX_RATE_HIGH, ADDR_TX_RATE_LOW, ADDR_MOD_CTRL2,
        ADDR_DEV_LOW, ADDR_OFS_LOW, ADDR_OFS_HIGH};
    logic [7:0] rv [6] = '{8'h0a, 8'h3d, 8'h00, 8'h20, 8'h00, 8'h00};
    logic [15:0] rw [3] = '{16'h4000, 16'h1000, 16'h8000};
    int err_total = 0, comparisons = 0, seed = 60716, n, c, e, lim;

    sfc_freq_ctrl i_sfc_freq_ctrl (.clk, .nrst, .reg_we, .reg_addr, .reg_wdata, .reg_rdata_r,
        .tx_on, .rx_on, .tx_fifo_mode, .tx_pkt_busy, .afc_en, .afc_gear, .afc_shwait,
        .rx_multi_pkt, .rx_bit_tick, .rx_freq_err, .preamble_det, .rx_pkt_end,
        .radio_state_r, .hop_applied_r, .retune_r, .high_band_r, .dev_hz_r,
        .lo_shift_mhz_r, .tx_bit_tick_r);
    sfc_host_model i_sfc_host_model (.clk, .reg_we, .reg_addr, .reg_wdata, .reg_rdata_r);

    // 20 MHz clock
    always #25 clk = ~clk;

    task automatic final_report();
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_out

    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_out({24'h00_0000, got}, {24'h00_0000, exp});
    endtask : cmp_reg

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_sfc_host_model.wr(a, d);
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        i_sfc_host_model.rd(a, d);
    endtask : rd

    // Signed manual offset in milli-Hz
    function automatic int exp_ofs(input logic [9:0] k, input logic hb);
        return int'($signed(k)) * (hb ? 2 : 1) * OFS_MHZ;
    endfunction : exp_ofs

    // One AFC cycle: two errors summed, scaled by gear, clamped to the limit
    function automatic int afc_step(input int k, input int er, input int g, input int lm);
        int s;
        s = k + ((2 * er) >>> (g + 1));
        return (s > lm) ? lm : ((s < -lm) ? -lm : s);
    endfunction : afc_step

    // RX bit ticks eight clocks apart; ends settled
    task automatic tick_n(input int k);
        repeat (k) begin
            @(posedge clk) rx_bit_tick <= 1'b1;
            @(posedge clk) rx_bit_tick <= 1'b0;
            repeat (6) @(posedge clk);
        end
        #1;
    endtask : tick_n

    task automatic wait_st(input logic [3:0] s);
        int k = 0;
        while (radio_state_r !== s && k < 50) begin
            @(posedge clk);
            #1 k++;
        end
        cmp_out(32'(radio_state_r), 32'(s));
    endtask : wait_st

    // Clocks from one TX tick to the next, bounded
    task automatic tick_gap(output int k);
        int w = 0;
        while (tx_bit_tick_r !== 1'b1 && w < 3000) begin
            @(posedge clk);
            #1 w++;
        end
        @(posedge clk);
        #1 k = 1;
        while (tx_bit_tick_r !== 1'b1 && k < 3000) begin
            @(posedge clk);
            #1 k++;
        end
    endtask : tick_gap

    // Hop write in TX or RX: tune for 20 cycles, then back
    task automatic hop_chk(input logic [6:0] a, input logic [3:0] s);
        int k = 0;
        sfc_hop_s x;
        logic [7:0] d;
        x = hop_applied_r;
        d = 8'($random(seed));
        if (a == ADDR_HOP_CH) x.ch = d;
        else x.step = d;
        wr(a, d);
        #1;
        cmp_out(32'(radio_state_r), 32'(ST_TUNE));
        cmp_out(32'(retune_r), 32'h0000_0001);
        cmp_out(32'(hop_applied_r), 32'(x));
        while (radio_state_r === ST_TUNE && k < 50) begin
            @(posedge clk);
            #1 k++;
        end
        cmp_out(32'(k), 32'h0000_0014);
        cmp_out(32'(radio_state_r), 32'(s));
    endtask : hop_chk

    // Hang guard, well past the expected run
    initial begin
        #(60_000 * 50);
        err_total++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        // Reset values, then read back random writes
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], r);
            cmp_reg(r, rv[i]);
            v = 8'($random(seed));
            wr(ra[i], v);
            rd(ra[i], r);
            cmp_reg(r, (ra[i] == ADDR_OFS_HIGH) ? (v & 8'h03) : v);
        end
        // Deviation corners and random codes, band toggled each pass
        for (int i = 0; i < 8; i++) begin
            dc = (i == 0) ? 9'h001 : (i == 1) ? 9'h1ff : 9'($random(seed));
            wr(ADDR_BAND, i[0] ? 8'h15 : 8'h35);
            wr(ADDR_MOD_CTRL2, {5'h00, dc[8], 2'h0});
            wr(ADDR_DEV_LOW, dc[7:0]);
            repeat (2) @(posedge clk);
            #1;
            cmp_out(32'(dev_hz_r), 32'(dc) * DEV_HZ);
            cmp_out(32'(high_band_r), {31'h0000_0000, ~i[0]});
        end
        // Manual offset in idle: signed code, band scaled, most negative code included
        for (int i = 0; i < 8; i++) begin
            oc = (i == 0) ? 10'h0a0 : (i == 1) ? 10'h360 : (i == 2) ? 10'h200 : 10'($random(seed));
            wr(ADDR_BAND, i[0] ? 8'h15 : 8'h35);
            wr(ADDR_OFS_LOW, oc[7:0]);
            wr(ADDR_OFS_HIGH, {6'h3f, oc[9:8]});
            rd(ADDR_OFS_HIGH, r);
            cmp_reg(r, {6'h00, oc[9:8]});
            cmp_out(lo_shift_mhz_r, 32'(exp_ofs(oc, ~i[0])));
        end
        // AFC acquire, freeze on preamble, clear per packet; one pass each for gears 0 to 2
        wr(ADDR_BAND, 8'h35);
        for (int g = 0; g < 3; g++) begin
            r = 8'h08 | 8'($random(seed) & 31);
            lim = int'(r) * 4;
            e = 10 + ($random(seed) & 31);
            if (g == 1) e = -e;
            wr(ADDR_AFC_LIMIT, r);
            @(posedge clk);
            afc_en <= 1'b1;
            afc_gear <= 3'(g);
            afc_shwait <= 3'h1;
            rx_multi_pkt <= 1'b0;
            rx_freq_err <= 10'(e);
            rx_on <= 1'b1;
            wait_st(ST_RX);
            c = 0;
            repeat (4) begin
                tick_n(4);
                c = afc_step(c, e, g, lim);
                cmp_out(lo_shift_mhz_r, 32'(c * 2 * OFS_MHZ));
            end
            rd(ADDR_AFC_CORR, r);
            cmp_reg(r, 8'(c));
            @(posedge clk) preamble_det <= 1'b1;
            @(posedge clk);
            preamble_det <= 1'b0;
            rx_freq_err <= 10'(-e);
            tick_n(8);
            cmp_out(lo_shift_mhz_r, 32'(c * 2 * OFS_MHZ));
            @(posedge clk);
            rx_multi_pkt <= 1'b1;
            rx_pkt_end <= 1'b1;
            @(posedge clk) rx_pkt_end <= 1'b0;
            tick_n(4);
            cmp_out(lo_shift_mhz_r, 32'(afc_step(0, -e, g, lim) * 2 * OFS_MHZ));
            @(posedge clk) rx_on <= 1'b0;
            wait_st(ST_IDLE);
        end
        // RX with AFC off uses the manual offset; cycle code zero gives none
        @(posedge clk);
        afc_en <= 1'b0;
        rx_on <= 1'b1;
        wait_st(ST_RX);
        tick_n(4);
        cmp_out(lo_shift_mhz_r, 32'(exp_ofs(oc, 1'b1)));
        @(posedge clk);
        afc_en <= 1'b1;
        afc_shwait <= 3'h0;
        tick_n(8);
        rd(ADDR_AFC_CORR, r);
        cmp_reg(r, 8'h00);
        cmp_out(lo_shift_mhz_r, 32'h0000_0000);
        hop_chk(ADDR_HOP_CH, ST_RX);
        @(posedge clk);
        rx_on <= 1'b0;
        tx_on <= 1'b1;
        wait_st(ST_TX);
        hop_chk(ADDR_HOP_STEP, ST_TX);
        // Hops during a FIFO packet wait for its end and use the latest bytes
        he = hop_applied_r;
        @(posedge clk);
        tx_fifo_mode <= 1'b1;
        tx_pkt_busy <= 1'b1;
        wr(ADDR_HOP_CH, 8'h5a);
        wr(ADDR_HOP_STEP, 8'h3c);
        wr(ADDR_HOP_CH, 8'ha5);
        #1;
        cmp_out(32'(radio_state_r), 32'(ST_TX));
        cmp_out(32'(hop_applied_r), 32'(he));
        @(posedge clk) tx_pkt_busy <= 1'b0;
        n = 0;
        while (retune_r !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        cmp_out(32'(hop_applied_r), 32'h0000_a53c);
        wait_st(ST_TX);
        // Bit period in clocks is 20 * 2^(16 + 5 * scale) / word
        @(posedge clk) tx_fifo_mode <= 1'b0;
        for (int t = 0; t < 3; t++) begin
            i_sfc_host_model.set_rate(rw[t], t == 2);
            tick_gap(n);
            tick_gap(n);
            cmp_out(32'(n), 32'((20 << (16 + 5 * (t / 2))) / int'(rw[t])));
        end
        rd(7'h58, r);
        cmp_reg(r, 8'h00);
        // No TX ticks while receiving
        @(posedge clk);
        tx_on <= 1'b0;
        rx_on <= 1'b1;
        wait_st(ST_RX);
        n = 0;
        repeat (400) begin
            @(posedge clk);
            #1;
            if (tx_bit_tick_r !== 1'b0) n++;
        end
        cmp_out(32'(n), 32'h0000_0000);
        final_report();
    end
endmodule : tb_sfc_freq_ctrl
`default_nettype wire
